// ---- src/rac_alarm_ctrl.sv ----
// RTC alarm control register, repeat logic, APB slave and interrupt
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/100ps
module rac_alarm_ctrl
  import rac_pkg::*;
#(
  parameter int HALF_TICKS = HALF_SEC_TICKS
) (
  // Clock and power-on reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Other reset sources, synchronous pulse
  input  wire logic        sys_reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // RTC side
  input  wire logic        rtc_on,
  input  wire logic [7:0]  time_match,
  input  wire logic        alarm_feb29,
  input  wire logic        leap_year,
  // Alarm outputs
  output logic             alarm_pulse,
  output logic             alarm_event,
  output logic             irq
);

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic                arm_reg;
  logic                chime_reg;
  logic                pulse_reg;
  logic [3:0]          intv_reg;
  logic [7:0]          rpt_reg;
  logic [IRQ_BITS-1:0] irq_stat_reg;
  logic [IRQ_BITS-1:0] irq_en_reg;
  logic                half_sec;
  logic                sec_phase;
  logic                read_unsafe;
  logic                acc;
  logic                wr;
  logic                rd;
  logic                mapped;
  logic                wr_ctrl;
  logic                auto_disarm;
  logic [31:0]         rdata_next;
  logic [IRQ_BITS-1:0] irq_set;
  logic [IRQ_BITS-1:0] irq_clr;

  rac_prescaler #(
    .HALF_TICKS (HALF_TICKS)
  ) u_prescaler (
    .pclk        (pclk),
    .presetn     (presetn),
    .rtc_on      (rtc_on),
    .half_sec    (half_sec),
    .sec_phase   (sec_phase),
    .read_unsafe (read_unsafe)
  );

  rac_match u_match (
    .pclk        (pclk),
    .presetn     (presetn),
    .half_sec    (half_sec),
    .sec_phase   (sec_phase),
    .armed       (arm_reg),
    .interval    (intv_reg),
    .match       (time_match),
    .alarm_feb29 (alarm_feb29),
    .leap_year   (leap_year),
    .alarm_event (alarm_event)
  );

  // Zero-wait APB slave; unmapped offsets answer with an error
  assign acc     = psel && penable;
  assign wr      = acc && pwrite;
  assign rd      = psel && !penable && !pwrite;
  assign mapped  = hit(paddr, OFS_ALARM_CTRL) || hit(paddr, OFS_IRQ_STATUS)
                   || hit(paddr, OFS_IRQ_CLEAR) || hit(paddr, OFS_IRQ_ENABLE);
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;
  assign wr_ctrl = wr && hit(paddr, OFS_ALARM_CTRL);

  // RULE2 last alarm disarms
  assign auto_disarm = alarm_event && (rpt_reg == RPT_RESET) && !chime_reg;

  // RULE14 only presetn (power-on) clears; sys_reset ignored here
  // RULE1 arm bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_reg <= 1'b0;
    end else if (auto_disarm) begin
      arm_reg <= 1'b0;
    end else if (wr_ctrl) begin
      arm_reg <= pwdata[BIT_ARM];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chime_reg <= 1'b0;
      intv_reg  <= INTV_RESET;
    end else if (wr_ctrl) begin
      chime_reg <= pwdata[BIT_CHIME];
      intv_reg  <= pwdata[INTV_MSB:INTV_LSB];
    end
  end

  // RULE16 decrement on event; event beats a same-cycle write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rpt_reg <= RPT_RESET;
    end else if (alarm_event) begin
      if (rpt_reg != RPT_RESET) begin
        rpt_reg <= rpt_reg - 8'h01;
      end else if (chime_reg) begin
        // RULE3 chime wrap
        rpt_reg <= RPT_WRAP;
      end else begin
        // RULE4 hold at zero
        rpt_reg <= RPT_RESET;
      end
    end else if (wr_ctrl) begin
      rpt_reg <= pwdata[RPT_MSB:RPT_LSB];
    end
  end

  // RULE16 pulse toggles per event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_reg <= 1'b0;
    end else if (alarm_event) begin
      pulse_reg <= ~pulse_reg;
    end else if (wr_ctrl && !arm_reg) begin
      // RULE5 initial level while disarmed
      pulse_reg <= pwdata[BIT_PIV];
    end
  end

  assign alarm_pulse = pulse_reg;

  // Interrupt: sticky status, set wins over clear
  assign irq_set = {auto_disarm, alarm_event};
  assign irq_clr = (wr && hit(paddr, OFS_IRQ_CLEAR)) ? pwdata[IRQ_BITS-1:0] : IRQ_RESET;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= IRQ_RESET;
      irq_en_reg   <= IRQ_RESET;
    end else if (sys_reset) begin
      irq_stat_reg <= IRQ_RESET;
      irq_en_reg   <= IRQ_RESET;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      if (wr && hit(paddr, OFS_IRQ_ENABLE)) begin
        irq_en_reg <= pwdata[IRQ_BITS-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_stat_reg | irq_set) & irq_en_reg);
    end
  end

  // Read data captured in the setup cycle, held through the access
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hit(paddr, OFS_ALARM_CTRL)) begin
      // RULE15 upper half reads zero
      rdata_next[BIT_ARM]           = arm_reg;
      rdata_next[BIT_CHIME]         = chime_reg;
      // RULE6 armed read returns pulse level
      rdata_next[BIT_PIV]           = pulse_reg;
      // RULE9 window sized for reads under 32 bus clocks
      rdata_next[BIT_UNSAFE]        = read_unsafe;
      rdata_next[INTV_MSB:INTV_LSB] = intv_reg;
      rdata_next[RPT_MSB:RPT_LSB]   = rpt_reg;
    end else if (hit(paddr, OFS_IRQ_STATUS)) begin
      rdata_next[IRQ_BITS-1:0] = irq_stat_reg;
    end else if (hit(paddr, OFS_IRQ_ENABLE)) begin
      rdata_next[IRQ_BITS-1:0] = irq_en_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd) begin
      prdata <= rdata_next;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_auto_disarm: assert property ( // RULE2
    alarm_event && rpt_reg == RPT_RESET && !chime_reg |=> !arm_reg)
    else $error("arm bit not cleared after last alarm");

  a_chime_wrap: assert property ( // RULE3
    alarm_event && rpt_reg == RPT_RESET && chime_reg |=> rpt_reg == RPT_WRAP)
    else $error("repeat count did not wrap in chime mode");

  a_rpt_hold: assert property ( // RULE4
    rpt_reg == RPT_RESET && !chime_reg && !wr_ctrl |=> rpt_reg == RPT_RESET)
    else $error("repeat count left zero without chime");

  a_rpt_dec: assert property ( // RULE16
    alarm_event && rpt_reg != RPT_RESET |=> rpt_reg == $past(rpt_reg) - 8'h01)
    else $error("repeat count not decremented on event");

  a_pulse_toggle: assert property ( // RULE16
    alarm_event |=> alarm_pulse != $past(alarm_pulse))
    else $error("pulse did not toggle on event");

  a_piv_locked: assert property ( // RULE6
    wr_ctrl && arm_reg && !alarm_event |=> alarm_pulse == $past(alarm_pulse))
    else $error("initial value write took effect while armed");

  a_piv_write: assert property ( // RULE5
    wr_ctrl && !arm_reg && !alarm_event |=> alarm_pulse == $past(pwdata[BIT_PIV]))
    else $error("initial value write lost while disarmed");

  a_arm_write: assert property ( // RULE1
    wr_ctrl && !auto_disarm |=> arm_reg == $past(pwdata[BIT_ARM]))
    else $error("arm bit did not follow write");

  a_no_event_off: assert property ( // RULE1
    !arm_reg |=> !alarm_event)
    else $error("alarm event while disarmed");

  a_upper_zero: assert property ( // RULE15
    psel && penable && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper bits of read data not zero");

  a_unsafe_off: assert property ( // RULE7
    !rtc_on ##1 !rtc_on |-> !read_unsafe)
    else $error("read-unsafe set with RTC off");

  a_irq_level: assert property (
    (irq_stat_reg & irq_en_reg) != IRQ_RESET |=> irq)
    else $error("interrupt not raised for enabled status");

  c_chime_wrap: cover property (alarm_event && rpt_reg == RPT_RESET && chime_reg);
  c_auto_disarm: cover property (auto_disarm);
  c_unsafe_read: cover property (rd && hit(paddr, OFS_ALARM_CTRL) && read_unsafe);
  c_irq: cover property ($rose(irq));

endmodule : rac_alarm_ctrl

// ---- pkg/rac_pkg.sv ----
// Constants for the RTC alarm control block
// Operation
// RULE1 - Bit 15 arms or disarms the alarm
// RULE2 - Last alarm without chime clears arm bit
// RULE3 - Chime lets repeat count wrap to 0xFF
// RULE4 - Without chime repeat count stops at 0x00
// RULE5 - Disarmed: written initial value sets pulse level
// RULE6 - Armed: initial value write ignored, reads pulse
// RULE7 - Read-unsafe set within 32 RTC clocks
// RULE8 - Software rereads until two reads agree
// RULE9 - Indication assumes reads under 32 bus clocks
// RULE10 - Interval field selects the alarm period
// RULE11 - Yearly February 29 alarm every four years
// RULE12 - Software avoids reserved interval codes
// RULE13 - Software avoids writes while read-unsafe
// RULE14 - Only power-on reset clears alarm control
// RULE15 - Upper sixteen bits read as zero
// RULE16 - Event decrements count and toggles pulse
// RULE17 - Event when unmasked time fields match
package rac_pkg;

  // Bus and clock
  localparam int          PCLK_HZ         = 100_000_000;
  localparam int          RTC_CLK_HZ      = 32_768;
  localparam int          RTC_DIV         = PCLK_HZ / RTC_CLK_HZ;
  localparam int          HALF_SEC_TICKS  = RTC_CLK_HZ / 2;
  localparam int          UNSAFE_TICKS    = 32;
  localparam int          READ_MAX_PCLKS  = 32;

  // Register offsets
  localparam logic [11:0] OFS_ALARM_CTRL  = 12'h000;
  localparam logic [11:0] OFS_IRQ_STATUS  = 12'h004;
  localparam logic [11:0] OFS_IRQ_CLEAR   = 12'h008;
  localparam logic [11:0] OFS_IRQ_ENABLE  = 12'h00C;

  // Alarm control field positions
  localparam int          BIT_ARM         = 15;
  localparam int          BIT_CHIME       = 14;
  localparam int          BIT_PIV         = 13;
  localparam int          BIT_UNSAFE      = 12;
  localparam int          INTV_LSB        = 8;
  localparam int          INTV_MSB        = 11;
  localparam int          RPT_LSB         = 0;
  localparam int          RPT_MSB         = 7;

  // Reset and wrap values
  localparam logic [7:0]  RPT_RESET       = 8'h00;
  localparam logic [7:0]  RPT_WRAP        = 8'hFF;
  localparam logic [3:0]  INTV_RESET      = 4'h0;
  localparam logic [1:0]  IRQ_RESET       = 2'h0;

  // Interrupt status bits
  localparam int          IRQ_ALARM       = 0;
  localparam int          IRQ_DISARM      = 1;
  localparam int          IRQ_BITS        = 2;

  // Match flag positions
  localparam int          M_SEC_ONES      = 0;
  localparam int          M_SEC_TENS      = 1;
  localparam int          M_MIN_ONES      = 2;
  localparam int          M_MIN_TENS      = 3;
  localparam int          M_HOUR          = 4;
  localparam int          M_WEEKDAY       = 5;
  localparam int          M_DAY           = 6;
  localparam int          M_MONTH         = 7;

  typedef enum logic [3:0] {
    RAC_HALF_SEC = 4'h0,
    RAC_SECOND   = 4'h1,
    RAC_TEN_SEC  = 4'h2,
    RAC_MINUTE   = 4'h3,
    RAC_TEN_MIN  = 4'h4,
    RAC_HOUR     = 4'h5,
    RAC_DAY      = 4'h6,
    RAC_WEEK     = 4'h7,
    RAC_MONTH    = 4'h8,
    RAC_YEAR     = 4'h9
  } rac_interval_t;

endpackage : rac_pkg

// ---- src/rac_prescaler.sv ----
// RTC prescaler: RTC clock enable, half-second rollover and read-unsafe window
`timescale 1ns/100ps
module rac_prescaler
  import rac_pkg::*;
#(
  parameter int HALF_TICKS = HALF_SEC_TICKS
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control
  input  wire logic rtc_on,
  // Status
  output logic      half_sec,
  output logic      sec_phase,
  output logic      read_unsafe
);

  logic [11:0] div_reg;
  logic [15:0] tick_reg;
  logic        rtc_en;
  logic [15:0] remain;

  assign rtc_en = rtc_on && (div_reg == 12'(RTC_DIV - 1));
  assign remain = 16'(HALF_TICKS - 1) - tick_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 12'h000;
    end else if (!rtc_on || rtc_en) begin
      div_reg <= 12'h000;
    end else begin
      div_reg <= div_reg + 12'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_reg <= 16'h0000;
      half_sec <= 1'b0;
      sec_phase <= 1'b0;
    end else begin
      half_sec <= 1'b0;
      if (rtc_en) begin
        if (remain == 16'h0000) begin
          tick_reg  <= 16'h0000;
          half_sec  <= 1'b1;
          sec_phase <= ~sec_phase;
        end else begin
          tick_reg <= tick_reg + 16'h0001;
        end
      end
    end
  end

  // RULE7 unsafe near rollover
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_unsafe <= 1'b0;
    end else begin
      read_unsafe <= rtc_on && (remain < 16'(UNSAFE_TICKS));
    end
  end

endmodule : rac_prescaler

// ---- src/rac_match.sv ----
// Alarm event generator from interval code and time field matches
`timescale 1ns/100ps
module rac_match
  import rac_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Timebase
  input  wire logic       half_sec,
  input  wire logic       sec_phase,
  // Setting
  input  wire logic       armed,
  input  wire logic [3:0] interval,
  input  wire logic [7:0] match,
  input  wire logic       alarm_feb29,
  input  wire logic       leap_year,
  // Result
  output logic            alarm_event
);

  // RULE17 unmasked fields match
  function automatic logic hits(input logic [3:0] code, input logic [7:0] m,
                                input logic feb29, input logic leap);
    logic [4:0] base;
    base = m[M_HOUR:M_SEC_ONES];
    case (code)
      RAC_HALF_SEC: hits = 1'b1;
      RAC_SECOND:   hits = 1'b1;
      RAC_TEN_SEC:  hits = m[M_SEC_ONES];
      RAC_MINUTE:   hits = &m[M_SEC_TENS:M_SEC_ONES];
      RAC_TEN_MIN:  hits = &m[M_MIN_ONES:M_SEC_ONES];
      RAC_HOUR:     hits = &m[M_MIN_TENS:M_SEC_ONES];
      RAC_DAY:      hits = &base;
      RAC_WEEK:     hits = (&base) && m[M_WEEKDAY];
      RAC_MONTH:    hits = (&base) && m[M_DAY];
      // RULE11 leap-day alarm only in leap years
      RAC_YEAR:     hits = (&base) && m[M_DAY] && m[M_MONTH] && (!feb29 || leap);
      default:      hits = 1'b0;
    endcase
  endfunction : hits

  logic whole_sec;

  // Falling phase marks the full-second rollover
  assign whole_sec = !sec_phase;

  // RULE10 interval selects period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_event <= 1'b0;
    end else begin
      alarm_event <= armed && half_sec
                     && (interval == RAC_HALF_SEC || whole_sec)
                     && hits(interval, match, alarm_feb29, leap_year);
    end
  end

endmodule : rac_match

// ---- verification/rac_tb.sv ----
// Self-checking testbench for the RTC alarm control block
`timescale 1ns/100ps
module testbench;
  import rac_pkg::*;

  typedef struct {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] exp;
    logic        err;
    logic        pulse;
  } rac_row_t;

  // Short half second keeps each alarm period near 6k or 12k bus clocks, under WAITN
  localparam int HT    = 2;
  localparam int NROWS = 7;
  localparam int WAITN = 13000;

  logic        pclk        = 1'b0;
  logic        presetn     = 1'b0;
  logic        sys_reset   = 1'b0;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [11:0] paddr       = 12'h000;
  logic [31:0] pwdata      = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rtc_on      = 1'b0;
  logic [7:0]  time_match  = 8'h00;
  logic        alarm_feb29 = 1'b0;
  logic        leap_year   = 1'b0;
  logic        alarm_pulse;
  logic        alarm_event;
  logic        irq;
  int          n_fail      = 0;
  int          checks      = 0;
  logic [31:0] rd;
  logic        er;
  rac_row_t    rows [NROWS];

  rac_alarm_ctrl #(.HALF_TICKS(HT)) rac_alarm_ctrl_i (
    .pclk        (pclk),
    .presetn     (presetn),
    .sys_reset   (sys_reset),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .rtc_on      (rtc_on),
    .time_match  (time_match),
    .alarm_feb29 (alarm_feb29),
    .leap_year   (leap_year),
    .alarm_pulse (alarm_pulse),
    .alarm_event (alarm_event),
    .irq         (irq)
  );

  always #5 pclk = ~pclk;

  task automatic tally_and_finish();
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("ERROR %0t got 0x%08h expected 0x%08h", $time, got, exp);
      n_fail++;
    end
  endtask : chk32

  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      $display("ERROR %0t got 0x%01h expected 0x%01h", $time, got, exp);
      n_fail++;
    end
  endtask : chk1

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 64) begin
      n_fail++;
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk32(rd, exp);
  endtask : rd_chk

  // Control write with the RTC held off, so the word is never read-unsafe
  task automatic ctrl_wr(input logic [31:0] wd);
    @(posedge pclk);
    rtc_on <= 1'b0;
    apb(1'b1, OFS_ALARM_CTRL, wd);
    rtc_on <= 1'b1;
  endtask : ctrl_wr

  // Reads the control word until two reads in a row agree
  task automatic safe_chk(input logic [31:0] exp);
    logic [31:0] prev;
    int          n;
    apb(1'b0, OFS_ALARM_CTRL, 32'h0000_0000);
    for (n = 0; n < 8; n++) begin
      prev = rd;
      apb(1'b0, OFS_ALARM_CTRL, 32'h0000_0000);
      if (rd === prev)
        break;
    end
    chk1(n < 8, 1'b1);
    chk32(rd, exp);
  endtask : safe_chk

  // Waits for one alarm event, then one more edge for the register update
  task automatic wait_event();
    int i;
    for (i = 0; i < WAITN; i++) begin
      @(posedge pclk);
      if (alarm_event === 1'b1)
        break;
    end
    chk1(i < WAITN, 1'b1);
    if (i == WAITN)
      tally_and_finish();
    @(posedge pclk);
  endtask : wait_event

  task automatic wait_none();
    logic hit;
    hit = 1'b0;
    repeat (WAITN) begin
      @(posedge pclk);
      if (alarm_event !== 1'b0)
        hit = 1'b1;
    end
    chk1(hit, 1'b0);
  endtask : wait_none

  initial begin
    rows[0] = '{OFS_ALARM_CTRL, 32'hFFFF_79A5, 32'h0000_69A5, 1'b0, 1'b1};
    rows[1] = '{OFS_ALARM_CTRL, 32'h0000_0000, 32'h0000_0000, 1'b0, 1'b0};
    rows[2] = '{OFS_IRQ_STATUS, 32'h0000_0003, 32'h0000_0000, 1'b0, 1'b0};
    rows[3] = '{OFS_IRQ_CLEAR, 32'h0000_0003, 32'h0000_0000, 1'b0, 1'b0};
    rows[4] = '{12'h010, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1, 1'b0};
    rows[5] = '{12'hFFC, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1, 1'b0};
    rows[6] = '{OFS_IRQ_ENABLE, 32'hFFFF_FFFF, 32'h0000_0003, 1'b0, 1'b0};
    repeat (12) @(posedge pclk);
    chk1(alarm_pulse, 1'b0);
    chk1(irq, 1'b0);
    presetn <= 1'b1;
    rd_chk(OFS_ALARM_CTRL, 32'h0000_0000);
    rd_chk(OFS_IRQ_STATUS, 32'h0000_0000);
    rd_chk(OFS_IRQ_ENABLE, 32'h0000_0000);
    // Register table: write, read back, check fault and pulse level
    for (int r = 0; r < NROWS; r++) begin
      apb(1'b1, rows[r].addr, rows[r].wdata);
      rd_chk(rows[r].addr, rows[r].exp);
      chk1(er, rows[r].err);
      chk1(alarm_pulse, rows[r].pulse);
    end
    // Countdown without chime, then auto-disarm
    time_match <= 8'hFF;
    ctrl_wr(32'h0000_8001);
    rd_chk(OFS_ALARM_CTRL, 32'h0000_9001);
    ctrl_wr(32'h0000_A001);
    rd_chk(OFS_ALARM_CTRL, 32'h0000_9001);
    wait_event();
    chk1(alarm_pulse, 1'b1);
    safe_chk(32'h0000_B000);
    wait_event();
    safe_chk(32'h0000_1000);
    rd_chk(OFS_IRQ_STATUS, 32'h0000_0003);
    chk1(irq, 1'b1);
    apb(1'b1, OFS_IRQ_CLEAR, 32'h0000_0003);
    rd_chk(OFS_IRQ_STATUS, 32'h0000_0000);
    chk1(irq, 1'b0);
    wait_none();
    rd_chk(OFS_ALARM_CTRL, 32'h0000_1000);
    // Chime wraps the count and keeps the alarm armed
    ctrl_wr(32'h0000_C000);
    wait_event();
    safe_chk(32'h0000_F0FF);
    ctrl_wr(32'h0000_0000);
    // Other reset source leaves the control register alone
    ctrl_wr(32'h0000_2305);
    @(posedge pclk);
    sys_reset <= 1'b1;
    @(posedge pclk);
    sys_reset <= 1'b0;
    rd_chk(OFS_ALARM_CTRL, 32'h0000_3305);
    rd_chk(OFS_IRQ_ENABLE, 32'h0000_0000);
    // Minute interval needs the seconds fields to match
    time_match <= 8'hFE;
    ctrl_wr(32'h0000_A305);
    wait_none();
    time_match <= 8'hFF;
    wait_event();
    safe_chk(32'h0000_9304);
    ctrl_wr(32'h0000_0000);
    // Yearly on February 29 fires only in a leap year
    alarm_feb29 <= 1'b1;
    ctrl_wr(32'h0000_A901);
    wait_none();
    leap_year <= 1'b1;
    wait_event();
    safe_chk(32'h0000_9900);
    ctrl_wr(32'h0000_0000);
    // Power-on reset in mid-run clears the register
    ctrl_wr(32'h0000_2305);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    chk1(alarm_pulse, 1'b0);
    presetn <= 1'b1;
    rd_chk(OFS_ALARM_CTRL, 32'h0000_1000);
    rd_chk(OFS_IRQ_ENABLE, 32'h0000_0000);
    tally_and_finish();
  end

endmodule : testbench
